// *** ocdc_pkg.sv ***
// Shared constants, types and helpers of the oscillator and divider control block
package ocdc_pkg;

	// Register byte offsets on the Avalon slave
	localparam logic [7:0] ADDR_OSC_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CLK_DIV   = 8'h04;
	localparam logic [7:0] ADDR_PLL_FBD   = 8'h08;
	localparam logic [7:0] ADDR_FRC_TUN   = 8'h0C;
	localparam logic [7:0] ADDR_UNLOCK    = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;

	// Oscillator control field positions
	localparam int OSC_SWREQ_BIT = 0;
	localparam int OSC_SECEN_BIT = 1;
	localparam int OSC_CFAIL_BIT = 3;
	localparam int OSC_NSRC_LSB  = 8;
	localparam int OSC_CSRC_LSB  = 12;

	// Clock divisor field positions
	localparam int CDV_PRE_LSB   = 0;
	localparam int CDV_POST_LSB  = 6;
	localparam int CDV_FRC_LSB   = 8;
	localparam int CDV_DOZE_RATIO_ENABLE_BIT = 11;
	localparam int CDV_DOZE_LSB  = 12;
	localparam int CDV_ROI_BIT   = 15;

	// Implemented bits and power-on values
	localparam logic [15:0] CDV_WMASK = 16'hFFDF;
	localparam logic [15:0] FBD_WMASK = 16'h01FF;
	localparam logic [15:0] TUN_WMASK = 16'h003F;
	localparam logic [15:0] CDV_RST   = 16'h3040;
	localparam logic [15:0] FBD_RST   = 16'h0030;
	localparam logic [15:0] TUN_RST   = 16'h0000;

	// Offsets added to pre-divider and feedback codes
	localparam logic [5:0] PRE_OFFSET = 6'h02;
	localparam logic [9:0] FBD_OFFSET = 10'h002;

	// Post-divider codes and divisors
	localparam logic [1:0] POST_CODE_DIV2 = 2'h0;
	localparam logic [1:0] POST_CODE_DIV4 = 2'h1;
	localparam logic [1:0] POST_CODE_DIV8 = 2'h3;
	localparam logic [3:0] POST_DIV2      = 4'h2;
	localparam logic [3:0] POST_DIV4      = 4'h4;
	localparam logic [3:0] POST_DIV8      = 4'h8;

	// Fast RC divider: the all-ones code jumps to 256, skipping 128
	localparam logic [2:0] FRC_CODE_MAX = 3'h7;
	localparam logic [8:0] FRC_DIV_MAX  = 9'h100;

	// Interrupt status bits
	localparam int IRQ_W        = 3;
	localparam int IRQ_CFAIL    = 0;
	localparam int IRQ_SWDONE   = 1;
	localparam int IRQ_DOZE_REC = 2;

	// Unlock keys, values arbitrary
	localparam logic [15:0] UNLOCK_KEY_A = 16'h5A3C;
	localparam logic [15:0] UNLOCK_KEY_B = 16'hC35A;

	// Timing
	localparam int CLK_PERIOD_NS    = 40;
	localparam int UNLOCK_WINDOW_NS = 400;
	localparam int UNLOCK_WINDOW_CY = UNLOCK_WINDOW_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		OCDC_UL_IDLE = 2'b00,
		OCDC_UL_HALF = 2'b01,
		OCDC_UL_OPEN = 2'b10
	} ocdc_ul_state_t;

	// Power of two for a 3-bit code
	function automatic logic [8:0] ocdc_pow2(input logic [2:0] code);
		ocdc_pow2 = 9'h001 << code;
	endfunction

	// Fast RC divisor for a 3-bit code; not a plain power of two at the top code
	function automatic logic [8:0] ocdc_frc_div(input logic [2:0] code);
		ocdc_frc_div = (code == FRC_CODE_MAX) ? FRC_DIV_MAX : ocdc_pow2(code);
	endfunction

	// Byte-lane merge of a 16-bit register, unimplemented bits forced to zero
	function automatic logic [15:0] ocdc_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be, input logic [15:0] wmask);
		logic [15:0] v;
		v = old;
		if (be[0]) begin
			v[7:0] = wd[7:0];
		end
		if (be[1]) begin
			v[15:8] = wd[15:8];
		end
		ocdc_merge = v & wmask;
	endfunction

endpackage

// *** ocdc_unlock.sv ***
// Unlock sequence detector guarding oscillator control writes
`timescale 1ns/1ps
module ocdc_unlock
	import ocdc_pkg::*;
#(
	parameter int WINDOW_CY = UNLOCK_WINDOW_CY
) (
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        soft_reset,
	// Key writes and consumption
	input  wire logic        key_we,
	input  wire logic [15:0] key_data,
	input  wire logic        consume,
	// Status
	output logic             unlocked
);

	generate
		if (WINDOW_CY < 1 || WINDOW_CY > 255) begin : g_chk
			$error("ocdc_unlock: WINDOW_CY out of range");
		end
	endgenerate

	ocdc_ul_state_t state_r;
	logic [7:0]     win_r;

	// Two keys in order open a short window for one write
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= OCDC_UL_IDLE;
			win_r   <= 8'h00;
		end else if (soft_reset) begin
			state_r <= OCDC_UL_IDLE;
			win_r   <= 8'h00;
		end else begin
			case (state_r)
				OCDC_UL_IDLE: begin
					if (key_we && key_data == UNLOCK_KEY_A) begin
						state_r <= OCDC_UL_HALF;
					end
				end
				OCDC_UL_HALF: begin
					if (key_we && key_data == UNLOCK_KEY_B) begin
						state_r <= OCDC_UL_OPEN;
						win_r   <= 8'(WINDOW_CY);
					end else if (key_we || consume) begin
						state_r <= OCDC_UL_IDLE;
					end
				end
				OCDC_UL_OPEN: begin
					// One write per sequence; stale windows close
					if (consume || win_r == 8'h00) begin
						state_r <= OCDC_UL_IDLE;
					end else begin
						win_r <= win_r - 8'h01;
					end
				end
				default: begin
					state_r <= OCDC_UL_IDLE;
				end
			endcase
		end
	end

	assign unlocked = (state_r == OCDC_UL_OPEN);

endmodule

// *** ocdc_ratediv.sv ***
// Power-of-two tick divider for the doze ratio
`timescale 1ns/1ps
module ocdc_ratediv
	import ocdc_pkg::*;
#(
	parameter int CW = 8
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// Rate control
	input  wire logic       tick_in,
	input  wire logic [2:0] ratio_log2,
	input  wire logic       enable,
	// Divided tick
	output logic            tick_out
);

	generate
		if (CW < 7) begin : g_chk
			$error("ocdc_ratediv: CW too small for divide-by-128");
		end
	endgenerate

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] limit;

	// Disabled doze means every tick passes
	assign limit = enable ? CW'(ocdc_pow2(ratio_log2) - 9'h001) : '0;

	// Counter restarts at the limit so a ratio change takes effect quickly
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r    <= '0;
			tick_out <= 1'b0;
		end else if (tick_in) begin
			if (cnt_r >= limit) begin
				cnt_r    <= '0;
				tick_out <= 1'b1;
			end else begin
				cnt_r    <= cnt_r + CW'(1);
				tick_out <= 1'b0;
			end
		end else begin
			tick_out <= 1'b0;
		end
	end

endmodule

// *** ocdc_top.sv ***
// Oscillator control, clock divisor, PLL and trim registers on Avalon-MM
//
// Functional notes
// - Monitor failure sets clock-fail flag, software clears
// - Secondary oscillator enable follows written bit
// - Switch request cleared once switch completes
// - Oscillator control writes need prior unlock sequence
// - Only power-on reset restores these registers
// - Recover-on-interrupt clears doze enable on interrupt
// - Fast RC divider gives 1 to 256
// - Post-divider code zero divides by two
// - Feedback multiplier equals field plus two
// - Trim is signed, zero nominal
// - Unimplemented bits read zero, ignore writes
// - Instruction clock is oscillator clock over two
`timescale 1ns/1ps
module ocdc_top
	import ocdc_pkg::*;
#(
	parameter int UNLOCK_CY = UNLOCK_WINDOW_CY
) (
	// Clock and resets
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        soft_reset,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Clock system status, same clock domain
	input  wire logic [2:0]  cfg_new_source,
	input  wire logic [2:0]  cur_source,
	input  wire logic        switch_done,
	input  wire logic        fail_detect,
	input  wire logic        irq_event,
	// Oscillator controls
	output logic [2:0]       new_source_select,
	output logic             switch_request,
	output logic             secondary_osc_enable,
	// Divider settings
	output logic             doze_ratio_enable,
	output logic [8:0]       fast_rc_divisor,
	output logic [5:0]       pll_pre_divisor,
	output logic [3:0]       pll_post_divisor,
	output logic [9:0]       pll_feedback_multiplier,
	output logic [5:0]       fast_rc_trim,
	// Clock ticks
	output logic             instr_tick,
	output logic             cpu_tick,
	// Interrupt
	output logic             irq
);

	logic               ack_r;
	logic               req;
	logic               wr_go;
	logic [15:0]        wd;
	logic [1:0]         be;
	logic [31:0]        readdata_r;
	logic               unlocked;
	logic               osc_try;
	logic               osc_wr;
	logic               cfg_loaded_r;
	logic [2:0]         nsrc_r;
	logic               swreq_r;
	logic               secen_r;
	logic               cfail_r;
	logic [15:0]        clock_divisor_r;
	logic [15:0]        pll_feedback_divisor_r;
	logic [15:0]        frctun_r;
	logic [IRQ_W-1:0]   irq_stat_r;
	logic [IRQ_W-1:0]   irq_mask_r;
	logic [IRQ_W-1:0]   irq_ev;
	logic               recover_on_interrupt;
	logic               doze_en;
	logic               instr_r;
	logic [15:0]        osc_view;

	// One wait state per access: request seen, then answered
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_r;
	assign wr_go           = avs_write & ack_r;
	assign wd              = avs_writedata[15:0];
	assign be              = avs_byteenable[1:0];
	assign avs_readdata    = readdata_r;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Unlock gate; every attempt on the register uses up the window
	assign osc_try = wr_go && avs_address == ADDR_OSC_CTRL;
	assign osc_wr  = osc_try && unlocked;

	ocdc_unlock #(
		.WINDOW_CY (UNLOCK_CY)
	) u_unlock (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.soft_reset(soft_reset),
		.key_we    (wr_go && avs_address == ADDR_UNLOCK),
		.key_data  (wd),
		.consume   (osc_try),
		.unlocked  (unlocked)
	);

	// New source is a strap, caught on the first edge after power-on
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_loaded_r <= 1'b0;
			nsrc_r       <= 3'h0;
		end else if (!cfg_loaded_r) begin
			cfg_loaded_r <= 1'b1;
			nsrc_r       <= cfg_new_source;
		end else if (osc_wr && be[1]) begin
			nsrc_r <= wd[OSC_NSRC_LSB +: 3];
		end
	end

	// Secondary oscillator enable; soft reset leaves it alone
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			secen_r <= 1'b0;
		end else if (osc_wr && be[0]) begin
			secen_r <= wd[OSC_SECEN_BIT];
		end
	end

	// Switch request: a new request wins over a same-cycle completion
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			swreq_r <= 1'b0;
		end else if (osc_wr && be[0] && wd[OSC_SWREQ_BIT]) begin
			swreq_r <= 1'b1;
		end else if (switch_done || (swreq_r && nsrc_r == cur_source)) begin
			swreq_r <= 1'b0;
		end
	end

	// Clock-fail flag: writing zero clears, failure set wins
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfail_r <= 1'b0;
		end else if (fail_detect) begin
			cfail_r <= 1'b1;
		end else if (osc_wr && be[0] && !wd[OSC_CFAIL_BIT]) begin
			cfail_r <= 1'b0;
		end
	end

	assign recover_on_interrupt     = clock_divisor_r[CDV_ROI_BIT];
	assign doze_en = clock_divisor_r[CDV_DOZE_RATIO_ENABLE_BIT];

	// Clock divisor; interrupt recovery overrides a same-cycle write
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clock_divisor_r <= CDV_RST;
		end else begin
			if (wr_go && avs_address == ADDR_CLK_DIV) begin
				clock_divisor_r <= ocdc_merge(clock_divisor_r, wd, be, CDV_WMASK);
			end
			if (irq_event && recover_on_interrupt) begin
				clock_divisor_r[CDV_DOZE_RATIO_ENABLE_BIT] <= 1'b0;
			end
		end
	end

	// PLL feedback and trim registers, power-on reset only
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pll_feedback_divisor_r <= FBD_RST;
			frctun_r <= TUN_RST;
		end else begin
			if (wr_go && avs_address == ADDR_PLL_FBD) begin
				pll_feedback_divisor_r <= ocdc_merge(pll_feedback_divisor_r, wd, be, FBD_WMASK);
			end
			if (wr_go && avs_address == ADDR_FRC_TUN) begin
				frctun_r <= ocdc_merge(frctun_r, wd, be, TUN_WMASK);
			end
		end
	end

	// Sticky events, write one to clear, new event wins
	assign irq_ev[IRQ_CFAIL]    = fail_detect;
	assign irq_ev[IRQ_SWDONE]   = swreq_r & switch_done;
	assign irq_ev[IRQ_DOZE_REC] = irq_event & recover_on_interrupt & doze_en;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_r <= '0;
		end else if (wr_go && avs_address == ADDR_IRQ_STAT && be[0]) begin
			irq_stat_r <= (irq_stat_r & ~wd[IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat_r <= irq_stat_r | irq_ev;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask_r <= '0;
		end else if (wr_go && avs_address == ADDR_IRQ_MASK && be[0]) begin
			irq_mask_r <= wd[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Readback view of oscillator control; gaps stay zero
	always_comb begin
		osc_view = 16'h0000;
		osc_view[OSC_CSRC_LSB +: 3] = cur_source;
		osc_view[OSC_NSRC_LSB +: 3] = nsrc_r;
		osc_view[OSC_CFAIL_BIT]     = cfail_r;
		osc_view[OSC_SECEN_BIT]     = secen_r;
		osc_view[OSC_SWREQ_BIT]     = swreq_r;
	end

	// Read data latched on the waiting cycle, valid when waitrequest drops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			readdata_r <= 32'h0000_0000;
		end else if (avs_read && !ack_r) begin
			if (avs_address == ADDR_OSC_CTRL) begin
				readdata_r <= {16'h0000, osc_view};
			end else if (avs_address == ADDR_CLK_DIV) begin
				readdata_r <= {16'h0000, clock_divisor_r};
			end else if (avs_address == ADDR_PLL_FBD) begin
				readdata_r <= {16'h0000, pll_feedback_divisor_r};
			end else if (avs_address == ADDR_FRC_TUN) begin
				readdata_r <= {16'h0000, frctun_r};
			end else if (avs_address == ADDR_IRQ_STAT) begin
				readdata_r <= {29'h0, irq_stat_r};
			end else if (avs_address == ADDR_IRQ_MASK) begin
				readdata_r <= {29'h0, irq_mask_r};
			end else begin
				readdata_r <= 32'h0000_0000;
			end
		end
	end

	// Decoded divider settings, registered for clean outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fast_rc_divisor         <= 9'h001;
			pll_pre_divisor         <= PRE_OFFSET;
			pll_post_divisor        <= POST_DIV4;
			pll_feedback_multiplier <= {1'b0, FBD_RST[8:0]} + FBD_OFFSET;
			fast_rc_trim            <= 6'h00;
		end else begin
			fast_rc_divisor <= ocdc_frc_div(clock_divisor_r[CDV_FRC_LSB +: 3]);
			pll_pre_divisor <= {1'b0, clock_divisor_r[CDV_PRE_LSB +: 5]} + PRE_OFFSET;
			pll_feedback_multiplier <= {1'b0, pll_feedback_divisor_r[8:0]} + FBD_OFFSET;
			fast_rc_trim <= frctun_r[5:0];
			// Reserved post code gives zero so misuse is visible
			case (clock_divisor_r[CDV_POST_LSB +: 2])
				POST_CODE_DIV2: pll_post_divisor <= POST_DIV2;
				POST_CODE_DIV4: pll_post_divisor <= POST_DIV4;
				POST_CODE_DIV8: pll_post_divisor <= POST_DIV8;
				default:        pll_post_divisor <= 4'h0;
			endcase
		end
	end

	// Instruction clock tick: every second system clock
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			instr_r <= 1'b0;
		end else begin
			instr_r <= ~instr_r;
		end
	end

	assign instr_tick = instr_r;

	ocdc_ratediv #(
		.CW (8)
	) u_doze (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.tick_in   (instr_r),
		.ratio_log2(clock_divisor_r[CDV_DOZE_LSB +: 3]),
		.enable    (doze_en),
		.tick_out  (cpu_tick)
	);

	// Plain register outputs
	assign new_source_select    = nsrc_r;
	assign switch_request       = swreq_r;
	assign secondary_osc_enable = secen_r;
	assign doze_ratio_enable    = doze_en;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	property p_cfail_set;
		fail_detect |=> cfail_r && irq_stat_r[IRQ_CFAIL];
	endproperty
	a_cfail_set: assert property (p_cfail_set) else $error("clock fail flag not set");

	property p_secen_write;
		osc_wr && be[0] |=> secen_r == $past(wd[OSC_SECEN_BIT]);
	endproperty
	a_secen_write: assert property (p_secen_write) else $error("secondary enable not written");

	property p_swreq_done;
		switch_done && !(osc_wr && be[0] && wd[OSC_SWREQ_BIT]) |=> !swreq_r;
	endproperty
	a_swreq_done: assert property (p_swreq_done) else $error("switch request not cleared");

	property p_locked;
		osc_try && !unlocked && !switch_done && !fail_detect |=> $stable(nsrc_r) && $stable(secen_r);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write changed oscillator control");

	property p_soft_keep;
		soft_reset && !wr_go && !irq_event |=> $stable(clock_divisor_r) && $stable(pll_feedback_divisor_r) && $stable(frctun_r);
	endproperty
	a_soft_keep: assert property (p_soft_keep) else $error("soft reset touched clock registers");

	property p_roi;
		irq_event && recover_on_interrupt |=> !doze_en;
	endproperty
	a_roi: assert property (p_roi) else $error("interrupt did not end doze");

	property p_no_doze;
		!doze_en && instr_r |=> cpu_tick;
	endproperty
	a_no_doze: assert property (p_no_doze) else $error("cpu tick missing at 1:1");

	property p_frc;
		##1 $past(&clock_divisor_r[10:8]) ? fast_rc_divisor == 9'h100 : fast_rc_divisor == (9'h001 << $past(clock_divisor_r[10:8]));
	endproperty
	a_frc: assert property (p_frc) else $error("fast rc divisor wrong");

	property p_post;
		##1 ($past(clock_divisor_r[7:6]) == 2'b00) == (pll_post_divisor == POST_DIV2);
	endproperty
	a_post: assert property (p_post) else $error("post divisor wrong");

	property p_pre_fbd;
		##1 pll_pre_divisor == $past(clock_divisor_r[4:0]) + 6'h02 &&
			pll_feedback_multiplier == $past(pll_feedback_divisor_r[8:0]) + 10'h002;
	endproperty
	a_pre_fbd: assert property (p_pre_fbd) else $error("pre or feedback divisor wrong");

	property p_unimpl;
		avs_read && !avs_waitrequest && avs_address == ADDR_OSC_CTRL |->
			avs_readdata[31:15] == 17'h0 && !avs_readdata[11] && avs_readdata[7:4] == 4'h0 && !avs_readdata[2];
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read nonzero");

	property p_instr;
		instr_r |=> !instr_r ##1 instr_r;
	endproperty
	a_instr: assert property (p_instr) else $error("instruction tick not half rate");

	c_unlocked_write: cover property (osc_wr && be[0] && wd[OSC_SWREQ_BIT]);
	c_switch_done: cover property (swreq_r ##[1:50] switch_done);
	c_doze_recover: cover property (doze_en && recover_on_interrupt && irq_event);
	c_irq: cover property (irq);

endmodule

// *** ocdc_tb.sv ***
// Self-checking testbench of the oscillator and divider control block
`timescale 1ns/1ps
module ocdc_tb
	import ocdc_pkg::*;
;
	// Clock, resets and bus
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        soft_reset = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	// Clock system status
	logic [2:0]  cfg_new_source = 3'h5;
	logic [2:0]  cur_source = 3'h0;
	logic        switch_done = 1'b0;
	logic        fail_detect = 1'b0;
	logic        irq_event = 1'b0;
	// Design outputs
	logic [2:0]  new_source_select;
	logic        switch_request;
	logic        secondary_osc_enable;
	logic        doze_ratio_enable;
	logic [8:0]  fast_rc_divisor;
	logic [5:0]  pll_pre_divisor;
	logic [3:0]  pll_post_divisor;
	logic [9:0]  pll_feedback_multiplier;
	logic [5:0]  fast_rc_trim;
	logic        instr_tick;
	logic        cpu_tick;
	logic        irq;
	// Bench state
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          i;
	int          d;
	int          ni;
	int          nc;
	logic [15:0] v;
	logic [15:0] f;
	logic [15:0] t;

	ocdc_top i_ocdc_top (
		.clk_sys(clk_sys), .reset_n(reset_n), .soft_reset(soft_reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cfg_new_source(cfg_new_source), .cur_source(cur_source), .switch_done(switch_done),
		.fail_detect(fail_detect), .irq_event(irq_event), .new_source_select(new_source_select),
		.switch_request(switch_request), .secondary_osc_enable(secondary_osc_enable),
		.doze_ratio_enable(doze_ratio_enable), .fast_rc_divisor(fast_rc_divisor),
		.pll_pre_divisor(pll_pre_divisor), .pll_post_divisor(pll_post_divisor),
		.pll_feedback_multiplier(pll_feedback_multiplier), .fast_rc_trim(fast_rc_trim),
		.instr_tick(instr_tick), .cpu_tick(cpu_tick), .irq(irq)
	);

	// 25 MHz system clock
	always #20 clk_sys = ~clk_sys;

	// Hang guard, far above the expected run length
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (fails == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon access; request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic rd, input logic [7:0] a, input logic [15:0] wd, input logic [1:0] be,
		output logic [15:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= {16'h0000, wd};
		avs_byteenable <= {2'b00, be};
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] wd, input logic [1:0] be = 2'h3);
		logic [15:0] q;
		bus(1'b0, a, wd, be, q);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] q;
		bus(1'b1, a, 16'h0000, 2'h3, q);
		chk({16'h0000, q}, {16'h0000, exp});
	endtask

	task automatic unlock();
		wr(ADDR_UNLOCK, UNLOCK_KEY_A);
		wr(ADDR_UNLOCK, UNLOCK_KEY_B);
	endtask

	// Decoded outputs lag the register by a cycle
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic pulse(input int which);
		@(posedge clk_sys);
		case (which)
			0: switch_done <= 1'b1;
			1: fail_detect <= 1'b1;
			default: irq_event <= 1'b1;
		endcase
		@(posedge clk_sys);
		switch_done <= 1'b0;
		fail_detect <= 1'b0;
		irq_event <= 1'b0;
		settle();
	endtask

	function automatic logic [3:0] post_div(input logic [1:0] c);
		case (c)
			2'h0: post_div = 4'h2;
			2'h1: post_div = 4'h4;
			2'h3: post_div = 4'h8;
			default: post_div = 4'h0;
		endcase
	endfunction

	// Fast RC divisor: powers of two, top code gives 256
	function automatic logic [8:0] frc_div(input logic [2:0] c);
		frc_div = (c == 3'h7) ? 9'h100 : (9'h001 << c);
	endfunction

	// Expected cpu ticks in 128 instruction ticks
	function automatic int doze_ticks(input int code, input logic en);
		doze_ticks = en ? (128 >> code) : 128;
	endfunction

	// Main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		void'($urandom(32'hE8AE));
		settle();
		rdchk(ADDR_OSC_CTRL, 16'h0500);
		rdchk(ADDR_CLK_DIV, CDV_RST);
		chk(pll_feedback_multiplier, 10'h032);
		rdchk(8'h1C, 16'h0000);
		// Locked writes, a broken key sequence, then a proper one
		wr(ADDR_OSC_CTRL, 16'h0002);
		wr(ADDR_UNLOCK, UNLOCK_KEY_A);
		wr(ADDR_UNLOCK, 16'h1234);
		wr(ADDR_UNLOCK, UNLOCK_KEY_B);
		wr(ADDR_OSC_CTRL, 16'h0002);
		settle();
		chk(secondary_osc_enable, 1'b0);
		unlock();
		wr(ADDR_OSC_CTRL, 16'h0002);
		settle();
		chk(secondary_osc_enable, 1'b1);
		wr(ADDR_OSC_CTRL, 16'h0000);
		settle();
		chk(secondary_osc_enable, 1'b1);
		// Plain fast RC to fast RC with PLL, never PLL to PLL
		unlock();
		wr(ADDR_OSC_CTRL, 16'h0100, 2'h2);
		settle();
		chk(new_source_select, 3'h1);
		unlock();
		wr(ADDR_OSC_CTRL, 16'h0003, 2'h1);
		repeat (4) @(posedge clk_sys);
		chk(switch_request, 1'b1);
		pulse(0);
		chk(switch_request, 1'b0);
		rdchk(ADDR_IRQ_STAT, 16'h0002);
		// Redundant switch aborts by itself
		cur_source <= 3'h1;
		unlock();
		wr(ADDR_OSC_CTRL, 16'h0003, 2'h1);
		settle();
		chk(switch_request, 1'b0);
		// Clock failure flag and the interrupt path
		wr(ADDR_IRQ_STAT, 16'h0007);
		wr(ADDR_IRQ_MASK, 16'h0001);
		pulse(1);
		rdchk(ADDR_OSC_CTRL, 16'h110A);
		chk(irq, 1'b1);
		wr(ADDR_IRQ_MASK, 16'h0000);
		settle();
		chk(irq, 1'b0);
		wr(ADDR_IRQ_MASK, 16'h0001);
		settle();
		chk(irq, 1'b1);
		wr(ADDR_IRQ_STAT, 16'h0001);
		settle();
		chk(irq, 1'b0);
		unlock();
		wr(ADDR_OSC_CTRL, 16'h0006, 2'h1);
		rdchk(ADDR_OSC_CTRL, 16'h1102);
		// Divider, feedback and trim fields: corners, then random codes
		for (i = 0; i < 24; i++) begin
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			f = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			t = (i == 2) ? 16'h001F : (i == 3) ? 16'h0020 : 16'($urandom);
			if (v[7:6] == 2'h2) begin
				v[6] = 1'b1;
			end
			wr(ADDR_CLK_DIV, v);
			wr(ADDR_PLL_FBD, f);
			wr(ADDR_FRC_TUN, t);
			settle();
			chk(fast_rc_divisor, frc_div(v[10:8]));
			chk(pll_pre_divisor, v[4:0] + 6'h02);
			chk(pll_post_divisor, post_div(v[7:6]));
			chk(doze_ratio_enable, v[11]);
			chk(pll_feedback_multiplier, f[8:0] + 10'h002);
			chk(fast_rc_trim, t[5:0]);
			rdchk(ADDR_CLK_DIV, v & 16'hFFDF);
			rdchk(ADDR_PLL_FBD, f & 16'h01FF);
			rdchk(ADDR_FRC_TUN, t & 16'h003F);
		end
		// Doze ratios; phase of the window is free, so one tick of slack
		for (d = 0; d < 5; d++) begin
			wr(ADDR_CLK_DIV, (d < 4) ? (16'h0840 | 16'(d << 12)) : 16'h3040);
			settle();
			ni = 0;
			nc = 0;
			repeat (256) begin
				@(negedge clk_sys);
				ni += int'(instr_tick === 1'b1);
				nc += int'(cpu_tick === 1'b1);
			end
			chk(ni, 128);
			chk(32'(nc >= doze_ticks(d, d < 4) - 1 && nc <= doze_ticks(d, d < 4) + 1), 1);
		end
		// Recover on interrupt, on and off
		wr(ADDR_CLK_DIV, 16'hB840);
		pulse(2);
		chk(doze_ratio_enable, 1'b0);
		rdchk(ADDR_CLK_DIV, 16'hB040);
		rdchk(ADDR_IRQ_STAT, 16'h0004);
		wr(ADDR_CLK_DIV, 16'h3840);
		pulse(2);
		chk(doze_ratio_enable, 1'b1);
		// Other reset keeps registers and closes an open unlock window
		unlock();
		@(posedge clk_sys);
		soft_reset <= 1'b1;
		@(posedge clk_sys);
		soft_reset <= 1'b0;
		wr(ADDR_OSC_CTRL, 16'h0000, 2'h1);
		rdchk(ADDR_OSC_CTRL, 16'h1102);
		rdchk(ADDR_CLK_DIV, 16'h3840);
		// Power-on reset in mid-run
		cfg_new_source <= 3'h2;
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		settle();
		rdchk(ADDR_OSC_CTRL, 16'h1200);
		rdchk(ADDR_CLK_DIV, CDV_RST);
		rdchk(ADDR_PLL_FBD, FBD_RST);
		rdchk(ADDR_FRC_TUN, TUN_RST);
		chk(secondary_osc_enable, 1'b0);
		report_and_stop();
	end
endmodule
